// File: uart_regs_pkg.sv
// Constants for the serial port channel register interface.
// Assumes a 32-bit AXI4-Lite master; each register is one word at byte address 4 x index.
package uart_regs_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_PORT_CLOCK_CONTROL = 16'h4380;
    localparam logic [15:0] IDX_FRAME_MODE_CONFIG  = 16'h4382;
    localparam logic [15:0] IDX_BIT_RATE_SETTING   = 16'h4384;
    localparam logic [15:0] IDX_PORT_CONTROL       = 16'h4386;
    localparam logic [15:0] IDX_TRANSMIT_BYTE      = 16'h4388;
    localparam logic [15:0] IDX_RECEIVE_BYTE       = 16'h438a;
    localparam logic [15:0] IDX_STATUS_FLAGS       = 16'h438c;
    localparam logic [15:0] IDX_EVENT_ENABLE_MASK  = 16'h438e;

    // Writable bit masks; all other bits read as zero
    localparam logic [15:0] MASK_CLOCK_CONTROL = 16'h0133;
    localparam logic [15:0] MASK_FRAME_MODE    = 16'h077f;
    localparam logic [15:0] MASK_BIT_RATE      = 16'h0fff;
    localparam logic [15:0] MASK_PORT_CONTROL  = 16'h0003;
    localparam logic [15:0] MASK_BYTE          = 16'h00ff;
    localparam logic [15:0] MASK_EVENTS        = 16'h007f;

    localparam logic [15:0] RESET_CONFIG = 16'h0000;
    localparam logic [6:0]  RESET_FLAGS  = 7'h01;

    // Flag bit positions
    localparam int FLAG_TX_EMPTY  = 0;
    localparam int FLAG_RX_ONE    = 1;
    localparam int FLAG_RX_TWO    = 2;
    localparam int FLAG_OVERRUN   = 3;
    localparam int FLAG_PARITY    = 4;
    localparam int FLAG_FRAMING   = 5;
    localparam int FLAG_TX_FINISH = 6;
    localparam int FLAG_TX_BUSY   = 8;
    localparam int FLAG_RX_BUSY   = 9;

    // Control bit positions
    localparam int CTL_ENABLE     = 0;
    localparam int CTL_SOFT_RESET = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [1:0] RX_DEPTH = 2'h2;

endpackage

// File: uart_flag_register_interface.sv
// Register file and status flags of one asynchronous serial port channel.
// Assumes an AXI4-Lite master on aclk and a serial engine that reports events as one-cycle pulses.
//
// Overview of operation
// - Transmit-empty flag is one at reset, cleared by data write
// - Framing/parity flags clear on write one or data read
// - Received-byte flags clear only by reading receive data or by soft reset
// - Finish/overrun flags clear on write one; zero keeps
`timescale 1ns/1ps
`default_nettype none

module uart_flag_register_interface
    import uart_regs_pkg::*;
(
    input  wire logic        aclk,              // System clock, 100 MHz
    input  wire logic        aresetn,           // Synchronous reset, active low
    input  wire logic [31:0] s_axi_awaddr,      // Write address
    input  wire logic        s_axi_awvalid,     // Write address valid
    output logic             s_axi_awready,     // Write address ready
    input  wire logic [31:0] s_axi_wdata,       // Write data
    input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes
    input  wire logic        s_axi_wvalid,      // Write data valid
    output logic             s_axi_wready,      // Write data ready
    output logic [1:0]       s_axi_bresp,       // Write response
    output logic             s_axi_bvalid,      // Write response valid
    input  wire logic        s_axi_bready,      // Write response ready
    input  wire logic [31:0] s_axi_araddr,      // Read address
    input  wire logic        s_axi_arvalid,     // Read address valid
    output logic             s_axi_arready,     // Read address ready
    output logic [31:0]      s_axi_rdata,       // Read data
    output logic [1:0]       s_axi_rresp,       // Read response
    output logic             s_axi_rvalid,      // Read data valid
    input  wire logic        s_axi_rready,      // Read data ready
    output logic [15:0]      port_clock_control,// Clock source and divider setting
    output logic [15:0]      frame_mode_config, // Frame format setting
    output logic [15:0]      bit_rate_setting,  // Bit rate setting
    output logic             port_enable,       // Channel enabled
    output logic [7:0]       tx_data,           // Byte waiting for the transmitter
    output logic             tx_data_valid,     // Transmit byte pending
    input  wire logic        tx_take,           // Transmitter took the pending byte
    input  wire logic        tx_end,            // Transmission finished pulse
    input  wire logic        tx_busy,           // Transmitter busy level
    input  wire logic        rx_valid,          // Received byte pulse
    input  wire logic [7:0]  rx_data,           // Received byte
    input  wire logic        rx_parity_err,     // Parity error with rx_valid
    input  wire logic        rx_framing_err,    // Framing error with rx_valid
    input  wire logic        rx_busy,           // Receiver busy level
    output logic             irq                // Interrupt request, level
);
    import uart_regs_pkg::*;

    function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] idx);
        reg_hit = (addr == {14'h0000, idx, 2'h0});
    endfunction

    function automatic logic known_addr(input logic [31:0] addr);
        known_addr = reg_hit(addr, IDX_PORT_CLOCK_CONTROL) || reg_hit(addr, IDX_FRAME_MODE_CONFIG)
                  || reg_hit(addr, IDX_BIT_RATE_SETTING)   || reg_hit(addr, IDX_PORT_CONTROL)
                  || reg_hit(addr, IDX_TRANSMIT_BYTE)      || reg_hit(addr, IDX_RECEIVE_BYTE)
                  || reg_hit(addr, IDX_STATUS_FLAGS)       || reg_hit(addr, IDX_EVENT_ENABLE_MASK);
    endfunction

    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] wr_lanes;
    logic [15:0] wr_value;
    logic [15:0] port_control;
    logic [15:0] event_enable_mask;
    logic [6:0]  flags;
    logic        tx_buffer_empty_flag;
    logic        rx_one_byte_flag;
    logic        rx_two_bytes_flag;
    logic        overrun_error_flag;
    logic        parity_error_flag;
    logic        framing_error_flag;
    logic        tx_finished_flag;
    logic        soft_reset;
    logic [1:0]  rx_count;
    logic [7:0]  rx_buf [0:1];
    logic        rx_pop;
    logic        pop_ok;
    logic        push_ok;
    logic        slot;
    logic [15:0] read_value;
    logic        tx_busy_seen;
    logic        rx_busy_seen;

    // Write happens once both address and data are held and no response is pending
    assign wr_fire  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_fire  = s_axi_arvalid && s_axi_arready;
    assign wr_lanes = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wr_value = wr_data[15:0];
    assign rx_pop   = rd_fire && reg_hit(s_axi_araddr, IDX_RECEIVE_BYTE);
    assign pop_ok   = rx_pop && (rx_count != 2'h0);
    assign push_ok  = rx_valid && ((rx_count != RX_DEPTH) || pop_ok);
    assign slot     = (rx_count - {1'b0, pop_ok}) != 2'h0;

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_addr       <= 32'h0000_0000;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel; the data register pops at the address handshake
    always_comb begin
        read_value = 16'h0000;
        if (reg_hit(s_axi_araddr, IDX_PORT_CLOCK_CONTROL)) begin
            read_value = port_clock_control;
        end else if (reg_hit(s_axi_araddr, IDX_FRAME_MODE_CONFIG)) begin
            read_value = frame_mode_config;
        end else if (reg_hit(s_axi_araddr, IDX_BIT_RATE_SETTING)) begin
            read_value = bit_rate_setting;
        end else if (reg_hit(s_axi_araddr, IDX_PORT_CONTROL)) begin
            read_value = port_control;
        end else if (reg_hit(s_axi_araddr, IDX_TRANSMIT_BYTE)) begin
            read_value = {8'h00, tx_data};
        end else if (reg_hit(s_axi_araddr, IDX_RECEIVE_BYTE)) begin
            read_value = (rx_count != 2'h0) ? {8'h00, rx_buf[0]} : 16'h0000;
        end else if (reg_hit(s_axi_araddr, IDX_STATUS_FLAGS)) begin
            read_value = {6'h00, rx_busy_seen, tx_busy_seen, 1'b0, flags};
        end else if (reg_hit(s_axi_araddr, IDX_EVENT_ENABLE_MASK)) begin
            read_value = event_enable_mask;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, read_value};
                s_axi_rresp   <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Configuration registers driving the serial engine, and the event enable mask driving irq
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_clock_control <= RESET_CONFIG;
            frame_mode_config  <= RESET_CONFIG;
            bit_rate_setting   <= RESET_CONFIG;
            port_control       <= RESET_CONFIG;
            event_enable_mask  <= RESET_CONFIG;
        end else begin
            // Soft reset request lasts one cycle so software need not clear it
            port_control[CTL_SOFT_RESET] <= 1'b0;
            if (wr_fire) begin
                if (reg_hit(wr_addr, IDX_PORT_CLOCK_CONTROL)) begin
                    port_clock_control <= (port_clock_control & ~wr_lanes) | (wr_value & wr_lanes & MASK_CLOCK_CONTROL);
                end else if (reg_hit(wr_addr, IDX_FRAME_MODE_CONFIG)) begin
                    frame_mode_config <= (frame_mode_config & ~wr_lanes) | (wr_value & wr_lanes & MASK_FRAME_MODE);
                end else if (reg_hit(wr_addr, IDX_BIT_RATE_SETTING)) begin
                    bit_rate_setting <= (bit_rate_setting & ~wr_lanes) | (wr_value & wr_lanes & MASK_BIT_RATE);
                end else if (reg_hit(wr_addr, IDX_PORT_CONTROL)) begin
                    port_control <= (port_control & ~wr_lanes) | (wr_value & wr_lanes & MASK_PORT_CONTROL);
                end else if (reg_hit(wr_addr, IDX_EVENT_ENABLE_MASK)) begin
                    event_enable_mask <= (event_enable_mask & ~wr_lanes) | (wr_value & wr_lanes & MASK_EVENTS);
                end
            end
        end
    end

    assign soft_reset = port_control[CTL_SOFT_RESET];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_enable  <= 1'b0;
            tx_busy_seen <= 1'b0;
            rx_busy_seen <= 1'b0;
        end else begin
            port_enable  <= port_control[CTL_ENABLE];
            tx_busy_seen <= tx_busy && !soft_reset;
            rx_busy_seen <= rx_busy && !soft_reset;
        end
    end

    // Transmit holding byte; a write in the take cycle refills it, so empty stays low
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            tx_data_valid        <= 1'b0;
            tx_buffer_empty_flag <= RESET_FLAGS[FLAG_TX_EMPTY];
        end else if (wr_fire && reg_hit(wr_addr, IDX_TRANSMIT_BYTE) && wr_strb[0]) begin
            tx_data_valid        <= 1'b1;
            tx_buffer_empty_flag <= 1'b0;
        end else if (tx_take && tx_data_valid) begin
            tx_data_valid        <= 1'b0;
            tx_buffer_empty_flag <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_data <= 8'h00;
        end else if (wr_fire && reg_hit(wr_addr, IDX_TRANSMIT_BYTE) && wr_strb[0]) begin
            tx_data <= wr_value[7:0];
        end
    end

    // Two-byte receive buffer; head is slot 0
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            rx_count <= 2'h0;
        end else begin
            rx_count <= rx_count + {1'b0, push_ok} - {1'b0, pop_ok};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buf[0] <= 8'h00;
            rx_buf[1] <= 8'h00;
        end else begin
            if (pop_ok) begin
                rx_buf[0] <= rx_buf[1];
            end
            if (push_ok) begin
                rx_buf[slot] <= rx_data;
            end
        end
    end

    // Byte-count flags follow the buffer, so only a data read or a soft reset lowers them
    assign rx_one_byte_flag  = (rx_count != 2'h0);
    assign rx_two_bytes_flag = (rx_count == RX_DEPTH);
    assign flags = {tx_finished_flag, framing_error_flag, parity_error_flag, overrun_error_flag,
                    rx_two_bytes_flag, rx_one_byte_flag, tx_buffer_empty_flag};

    // Error and finish flags; a new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            overrun_error_flag <= 1'b0;
            parity_error_flag  <= 1'b0;
            framing_error_flag <= 1'b0;
            tx_finished_flag   <= 1'b0;
        end else begin
            if (rx_valid && !push_ok) begin
                overrun_error_flag <= 1'b1;
            end else if (wr_fire && reg_hit(wr_addr, IDX_STATUS_FLAGS) && wr_strb[0] && wr_value[FLAG_OVERRUN]) begin
                overrun_error_flag <= 1'b0;
            end
            if (tx_end) begin
                tx_finished_flag <= 1'b1;
            end else if (wr_fire && reg_hit(wr_addr, IDX_STATUS_FLAGS) && wr_strb[0] && wr_value[FLAG_TX_FINISH]) begin
                tx_finished_flag <= 1'b0;
            end
            if (rx_valid && rx_parity_err) begin
                parity_error_flag <= 1'b1;
            end else if (rx_pop || (wr_fire && reg_hit(wr_addr, IDX_STATUS_FLAGS) && wr_strb[0]
                                    && wr_value[FLAG_PARITY])) begin
                parity_error_flag <= 1'b0;
            end
            if (rx_valid && rx_framing_err) begin
                framing_error_flag <= 1'b1;
            end else if (rx_pop || (wr_fire && reg_hit(wr_addr, IDX_STATUS_FLAGS) && wr_strb[0]
                                    && wr_value[FLAG_FRAMING])) begin
                framing_error_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & event_enable_mask[6:0]);
        end
    end

    a_tx_empty_reset: assert property (@(posedge aclk) !aresetn |=> flags[FLAG_TX_EMPTY])
        else $error("Transmit-empty flag not set after reset");

    a_tx_empty_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && reg_hit(wr_addr, IDX_TRANSMIT_BYTE) && wr_strb[0]) |=> !flags[FLAG_TX_EMPTY])
        else $error("Transmit-empty flag not cleared by data write");

    a_err_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (rx_pop && !rx_valid) |=> !flags[FLAG_PARITY] && !flags[FLAG_FRAMING])
        else $error("Error flags not cleared by data read");

    a_rx_flag_fall: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(flags[FLAG_RX_ONE]) |-> $past(rx_pop) || $past(soft_reset))
        else $error("Received-byte flag fell without a data read");

    a_w1c_zero_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (flags[FLAG_TX_FINISH] && wr_fire && reg_hit(wr_addr, IDX_STATUS_FLAGS)
         && !wr_value[FLAG_TX_FINISH] && !soft_reset) |=> flags[FLAG_TX_FINISH])
        else $error("Finish flag lost on a zero write");

    a_w1c_one_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && reg_hit(wr_addr, IDX_STATUS_FLAGS) && wr_strb[0] && wr_value[FLAG_OVERRUN]
         && !rx_valid) |=> !flags[FLAG_OVERRUN])
        else $error("Overrun flag not cleared by writing one");

    a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        ((|(flags & event_enable_mask[6:0])) |=> irq) and (!(|(flags & event_enable_mask[6:0])) |=> !irq))
        else $error("Interrupt does not follow enabled flags");

endmodule

`default_nettype wire

// File: uart_engine_model.sv
// Behavioural serial engine standing at the far side of the register block.
// Assumes the block's engine-side ports and one shared aclk; the bench calls recv hierarchically.
`timescale 1ns/1ps
`default_nettype none

module uart_engine_model (
    input  wire logic       aclk,           // System clock
    input  wire logic       aresetn,        // Synchronous reset, active low
    input  wire logic       tx_data_valid,  // Byte pending in the block
    input  wire logic       tx_stall,       // Holds the transmitter off
    output logic            tx_take,        // Took the pending byte
    output logic            tx_end,         // Frame finished pulse
    output logic            tx_busy,        // Frame on the line
    output logic            rx_valid,       // Received byte strobe
    output logic [7:0]      rx_data,        // Received byte
    output logic            rx_parity_err,  // Parity error with strobe
    output logic            rx_framing_err, // Framing error with strobe
    output logic            rx_busy         // Frame arriving
);
    logic [2:0] cnt;

    assign tx_busy = (cnt != 3'h0);

    // A frame lasts four cycles so that the block sees take, busy and end apart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_take <= 1'b0;
            tx_end  <= 1'b0;
            cnt     <= 3'h0;
        end else begin
            tx_take <= tx_data_valid && !tx_stall && !tx_take && !tx_busy;
            tx_end  <= (cnt == 3'h1);
            if (tx_take) begin
                cnt <= 3'h4;
            end else if (tx_busy) begin
                cnt <= cnt - 3'h1;
            end
        end
    end

    initial begin
        rx_valid       = 1'b0;
        rx_data        = 8'h00;
        rx_parity_err  = 1'b0;
        rx_framing_err = 1'b0;
        rx_busy        = 1'b0;
    end

    // Outside the strobe the lines carry inverted junk, never the last byte
    task automatic recv(input logic [7:0] d, input logic pe, input logic fe);
        @(posedge aclk);
        rx_busy        <= 1'b1;
        rx_valid       <= 1'b1;
        rx_data        <= d;
        rx_parity_err  <= pe;
        rx_framing_err <= fe;
        @(posedge aclk);
        rx_busy        <= 1'b0;
        rx_valid       <= 1'b0;
        rx_data        <= ~d;
        rx_parity_err  <= ~pe;
        rx_framing_err <= ~fe;
    endtask
endmodule

`default_nettype wire

// File: tb.sv
// Self-checking bench for the serial port register block.
// Assumes uart_regs_pkg and the engine model; registers sit at byte address 4 x index.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
    import uart_regs_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, tx_stall = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h3;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        port_enable, tx_data_valid, tx_take, tx_end, tx_busy, irq;
    logic        rx_valid, rx_parity_err, rx_framing_err, rx_busy;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] port_clock_control, frame_mode_config, bit_rate_setting;
    logic [7:0]  tx_data, rx_data;
    int          num_errors = 0;
    int          check_count = 0;
    logic [15:0] all_idx [8] = '{IDX_PORT_CLOCK_CONTROL, IDX_FRAME_MODE_CONFIG, IDX_BIT_RATE_SETTING,
        IDX_PORT_CONTROL, IDX_TRANSMIT_BYTE, IDX_RECEIVE_BYTE, IDX_STATUS_FLAGS, IDX_EVENT_ENABLE_MASK};
    logic [15:0] cfg_idx [4] = '{IDX_PORT_CLOCK_CONTROL, IDX_FRAME_MODE_CONFIG, IDX_BIT_RATE_SETTING,
        IDX_EVENT_ENABLE_MASK};
    logic [15:0] cfg_msk [4] = '{MASK_CLOCK_CONTROL, MASK_FRAME_MODE, MASK_BIT_RATE, MASK_EVENTS};

    uart_flag_register_interface uart_flag_register_interface_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .port_clock_control, .frame_mode_config, .bit_rate_setting, .port_enable, .tx_data,
        .tx_data_valid, .tx_take, .tx_end, .tx_busy, .rx_valid, .rx_data, .rx_parity_err,
        .rx_framing_err, .rx_busy, .irq);

    uart_engine_model uart_engine_model_i (
        .aclk, .aresetn, .tx_data_valid, .tx_stall, .tx_take, .tx_end, .tx_busy, .rx_valid,
        .rx_data, .rx_parity_err, .rx_framing_err, .rx_busy);

    always #5 aclk = ~aclk;

    task automatic print_verdict;
        $display("Errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= {14'h0000, idx, 2'h0};
        s_axi_wdata   <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // No cycle limit here; the watchdog ends a hung wait
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                `CHK(s_axi_bresp, er)
                break;
            end
        end
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= {14'h0000, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                `CHK(s_axi_rdata, {16'h0000, e})
                `CHK(s_axi_rresp, er)
                break;
            end
        end
    endtask

    task automatic rf(input logic [15:0] e);
        rd(IDX_STATUS_FLAGS, e, RESP_OKAY);
    endtask

    // Interrupt output is registered one cycle behind flag and mask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge aclk);
        #1;
        `CHK(irq, e)
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(all_idx[i], (i == 6) ? 16'h0001 : 16'h0000, RESP_OKAY);
        rd(16'h4390, 16'h0000, RESP_SLVERR);
        wr(16'h4390, 16'hffff, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            wr(cfg_idx[i], 16'hffff, RESP_OKAY);
            rd(cfg_idx[i], cfg_msk[i], RESP_OKAY);
        end
        `CHK(bit_rate_setting, MASK_BIT_RATE)
        `CHK(port_clock_control, MASK_CLOCK_CONTROL)
        `CHK(frame_mode_config, MASK_FRAME_MODE)
        // Only the low byte lane is enabled, so the high byte must survive
        s_axi_wstrb <= 4'h1;
        wr(IDX_BIT_RATE_SETTING, 16'h0000, RESP_OKAY);
        s_axi_wstrb <= 4'h3;
        rd(IDX_BIT_RATE_SETTING, 16'h0f00, RESP_OKAY);
        `CHK(bit_rate_setting, 16'h0f00)
        chk_irq(1'b1);
        wr(IDX_EVENT_ENABLE_MASK, 16'h0040, RESP_OKAY);
        chk_irq(1'b0);
        wr(IDX_PORT_CONTROL, 16'h0001, RESP_OKAY);
        rd(IDX_PORT_CONTROL, 16'h0001, RESP_OKAY);
        `CHK(port_enable, 1'b1)
        // Transmit held off so the empty flag can be seen low
        tx_stall <= 1'b1;
        wr(IDX_TRANSMIT_BYTE, 16'h00a5, RESP_OKAY);
        rf(16'h0000);
        `CHK(tx_data, 8'ha5)
        `CHK(tx_data_valid, 1'b1)
        chk_irq(1'b0);
        tx_stall <= 1'b0;
        repeat (12) @(posedge aclk);
        rf(16'h0041);
        chk_irq(1'b1);
        wr(IDX_STATUS_FLAGS, 16'h0000, RESP_OKAY);
        rf(16'h0041);
        wr(IDX_STATUS_FLAGS, 16'h0040, RESP_OKAY);
        rf(16'h0001);
        chk_irq(1'b0);
        uart_engine_model_i.recv(8'h11, 1'b1, 1'b0);
        uart_engine_model_i.recv(8'h22, 1'b0, 1'b1);
        uart_engine_model_i.recv(8'h33, 1'b0, 1'b0);
        rf(16'h003f);
        wr(IDX_STATUS_FLAGS, 16'h0007, RESP_OKAY);
        rf(16'h003f);
        rd(IDX_RECEIVE_BYTE, 16'h0011, RESP_OKAY);
        rf(16'h000b);
        wr(IDX_STATUS_FLAGS, 16'h0008, RESP_OKAY);
        rf(16'h0003);
        rd(IDX_RECEIVE_BYTE, 16'h0022, RESP_OKAY);
        rf(16'h0001);
        rd(IDX_RECEIVE_BYTE, 16'h0000, RESP_OKAY);
        uart_engine_model_i.recv(8'h44, 1'b1, 1'b1);
        rf(16'h0033);
        wr(IDX_STATUS_FLAGS, 16'h0030, RESP_OKAY);
        rf(16'h0003);
        rd(IDX_RECEIVE_BYTE, 16'h0044, RESP_OKAY);
        // Soft reset brings flags home but leaves the mask alone
        uart_engine_model_i.recv(8'h55, 1'b0, 1'b0);
        rf(16'h0003);
        wr(IDX_PORT_CONTROL, 16'h0003, RESP_OKAY);
        rf(16'h0001);
        rd(IDX_RECEIVE_BYTE, 16'h0000, RESP_OKAY);
        rd(IDX_EVENT_ENABLE_MASK, 16'h0040, RESP_OKAY);
        print_verdict();
    end
endmodule

`default_nettype wire
